// File: verilog/vasi_auto_slot_id.v
// Behaviour
// - After each system reset, arm and act only on first level-one acknowledge.
// - Without an interrupt source nobody claims; pass runs until bus error.
// - First-slot board counts five clocks from cycle start, then drives IACKOUT.
// - Other boards count until IACKIN, then four more clocks, then IACKOUT.
// - After the last board passes on, nobody acknowledges; timeout ends cycle.
// - Slot identifier is accumulated count divided by four, remainder dropped.
// - Identifier may be one off but always exceeds lower slots.
// - On completion, load the identifier register and set the done flag.
// - Once identification is done, writing 1 to the self-test bit increments the identifier.
// - Self-test bit resets to zero.
// - Boards without this logic may be mixed; identifiers stay distinct.
`include "vasi_defs.vh"

module vasi_auto_slot_id (
  input  wire       REF_CLK,             // System clock, 20 MHz
  input  wire       RESET,               // Synchronous reset, active high
  input  wire       SYSTEM_RESET_INPUT_N, // Bus system reset, active low
  input  wire       IACK_N,              // Bus acknowledge line, active low
  input  wire       AS_N,                // Bus address strobe, active low
  input  wire [2:0] IACK_LEVEL,          // Acknowledged level on A03..A01
  input  wire       IACKIN_N,            // Daisy-chain input, active low
  input  wire       FIRST_SLOT,          // Board is in slot one (system controller)
  input  wire       BERR_N,              // Bus error ending the cycle, active low
  input  wire       SELFTEST_WR,         // Write strobe to general control register
  input  wire       SLOT_ID_SELFTEST_BIT, // Self-test bit value on that write
  output reg        IACKOUT_N,           // Daisy-chain output, active low
  output reg  [7:0] SLOT_ID,             // Identifier register contents
  output reg        SLOT_ID_DONE_FLAG,   // Identification done status
  output reg        SELFTEST_BIT_Q       // Self-test bit as held in control register
);

  localparam ST_ARMED = 3'h0;
  localparam ST_COUNT = 3'h1;
  localparam ST_PASS  = 3'h2;
  localparam ST_HOLD  = 3'h3;
  localparam ST_DONE  = 3'h4;

  reg [2:0]             state_ff;
  reg [2:0]             nxt_state;
  reg [`VASI_CNT_W-1:0] cnt_ff;
  reg [`VASI_CNT_W-1:0] nxt_cnt;
  reg [7:0]             nxt_id;
  reg                   nxt_selftest;
  reg                   nxt_done;
  reg                   nxt_iackout_n;
  reg                   tmr_start;
  reg                   tmr_clear;
  wire                  tmr_done;
  wire                  l1_start;
  wire                  first_go;
  wire                  cyc_end;
  wire [3:0]            pass_clks;
  wire                  sys_rst_act;

  ////////////////////////////////////////////////////////////////////////////
  // Level-one acknowledge decode

  function is_level1;
    input       iack_n;
    input       as_n;
    input [2:0] lvl;
    begin
      is_level1 = !iack_n && !as_n && (lvl == `VASI_IACK_LEVEL1);
    end
  endfunction

  // unclaimed pass runs until bus error
  // we never acknowledge; the bus timer ends it
  function cycle_over;
    input iack_n;
    input berr_n;
    begin
      cycle_over = iack_n || !berr_n;
    end
  endfunction

  assign l1_start    = is_level1(IACK_N, AS_N, IACK_LEVEL);
  assign first_go    = l1_start && FIRST_SLOT;
  assign cyc_end     = cycle_over(IACK_N, BERR_N);
  assign sys_rst_act = !SYSTEM_RESET_INPUT_N;
  // First slot also counts the clock on which the cycle was taken
  assign pass_clks   = FIRST_SLOT ? `VASI_FIRST_SLOT_CLKS : `VASI_PASS_CLKS;

  ////////////////////////////////////////////////////////////////////////////
  // Pass-through delay timer

  vasi_pass_timer u_timer (
    .clk     (REF_CLK),
    .rst     (RESET),
    .clear   (tmr_clear),
    .start   (tmr_start),
    .count   (pass_clks),
    .done_ff (tmr_done)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always @*
  begin
    nxt_state     = state_ff;
    nxt_cnt       = cnt_ff;
    nxt_id        = SLOT_ID;
    nxt_done      = SLOT_ID_DONE_FLAG;
    nxt_iackout_n = 1'b1;
    tmr_start     = 1'b0;
    tmr_clear     = 1'b0;
    case (state_ff)
      ST_ARMED:
      begin
        // first slot times from the cycle start
        tmr_clear = !first_go;
        tmr_start = first_go;
        if (l1_start)
        begin
          nxt_state = ST_COUNT;
          nxt_cnt   = {{(`VASI_CNT_W-1){1'b0}}, 1'b1};
        end
      end
      ST_COUNT:
      begin
        // count only rises, so a later slot reads higher
        // saturate rather than wrap, keeping positions ordered
        if (cnt_ff != `VASI_CNT_MAX)
          nxt_cnt = cnt_ff + {{(`VASI_CNT_W-1){1'b0}}, 1'b1};
        if (FIRST_SLOT)
        begin
          tmr_start = 1'b1;
          nxt_state = ST_PASS;
        end
        else if (!IACKIN_N)
        begin
          tmr_start = 1'b1;
          nxt_state = ST_PASS;
        end
        else if (cyc_end)
          nxt_state = ST_HOLD;
      end
      ST_PASS:
      begin
        if (cyc_end)
          nxt_state = ST_HOLD;
        else if (tmr_done)
          nxt_iackout_n = 1'b0;
      end
      ST_HOLD:
      begin
        nxt_id    = cnt_ff[`VASI_ID_W+`VASI_DIV_SHIFT-1:`VASI_DIV_SHIFT];
        nxt_done  = 1'b1;
        nxt_state = ST_DONE;
      end
      ST_DONE:
      begin
        // Later acknowledge cycles are ignored until the next system reset
        tmr_clear = 1'b1;
        if (SELFTEST_WR && SLOT_ID_SELFTEST_BIT)
          nxt_id = SLOT_ID + 8'h01;
      end
      default:
        nxt_state = ST_ARMED;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-test bit of the control register

  always @*
  begin
    nxt_selftest = SELFTEST_BIT_Q;
    if (SELFTEST_WR)
      nxt_selftest = SLOT_ID_SELFTEST_BIT;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; system reset rearms but the identifier survives it until reload

  always @(posedge REF_CLK)
  begin
    if (RESET)
    begin
      state_ff          <= ST_ARMED;
      cnt_ff            <= {`VASI_CNT_W{1'b0}};
      IACKOUT_N         <= 1'b1;
      SLOT_ID           <= `VASI_ID_RST;
      SLOT_ID_DONE_FLAG <= 1'b0;
      SELFTEST_BIT_Q    <= 1'b0;
    end
    else
    begin
      if (sys_rst_act)
      begin
        state_ff          <= ST_ARMED;
        cnt_ff            <= {`VASI_CNT_W{1'b0}};
        IACKOUT_N         <= 1'b1;
        SLOT_ID_DONE_FLAG <= 1'b0;
        SELFTEST_BIT_Q    <= 1'b0;
      end
      else
      begin
        state_ff          <= nxt_state;
        cnt_ff            <= (state_ff == ST_PASS || state_ff == ST_HOLD) ? cnt_ff : nxt_cnt;
        // Chain output only leaves a flop, so no glitch passes the acknowledge on
        IACKOUT_N         <= (state_ff == ST_PASS) ? nxt_iackout_n : 1'b1;
        SLOT_ID           <= nxt_id;
        SLOT_ID_DONE_FLAG <= nxt_done;
        SELFTEST_BIT_Q    <= nxt_selftest;
      end
    end
  end

endmodule

// File: verilog/vasi_defs.vh
`ifndef VASI_DEFS_VH
`define VASI_DEFS_VH

// Clocks counted by the first-slot board before passing the acknowledge on
`define VASI_FIRST_SLOT_CLKS 4'h5
// Clocks counted by every other board after its daisy-chain input arrives
`define VASI_PASS_CLKS       4'h4
// Counter width; the count saturates rather than wrapping
`define VASI_CNT_W           10
`define VASI_CNT_MAX         10'h3FF
// Slot identifier is count divided by four: drop two low bits
`define VASI_DIV_SHIFT       2
`define VASI_ID_W            8
// Acknowledge level one on the three-bit level code
`define VASI_IACK_LEVEL1     3'h1
// Reset values
`define VASI_ID_RST          8'h00

`endif

// File: verilog/vasi_pass_timer.v
`include "vasi_defs.vh"

// Counts a fixed number of clocks after start, then holds done until clear
module vasi_pass_timer (
  input  wire       clk,    // System clock
  input  wire       rst,    // Synchronous reset, active high
  input  wire       clear,  // Return to idle
  input  wire       start,  // Begin counting
  input  wire [3:0] count,  // Clocks to wait
  output reg        done_ff // Wait finished
);

  reg [3:0] cnt_ff;
  reg       run_ff;
  reg [3:0] nxt_cnt;
  reg       nxt_run;
  reg       nxt_done;

  always @*
  begin
    nxt_cnt  = cnt_ff;
    nxt_run  = run_ff;
    nxt_done = done_ff;
    if (clear)
    begin
      nxt_cnt  = 4'h0;
      nxt_run  = 1'b0;
      nxt_done = 1'b0;
    end
    else if (start && !run_ff && !done_ff)
    begin
      nxt_cnt = 4'h1;
      nxt_run = 1'b1;
      if (count <= 4'h1)
      begin
        nxt_run  = 1'b0;
        nxt_done = 1'b1;
      end
    end
    else if (run_ff)
    begin
      nxt_cnt = cnt_ff + 4'h1;
      if (nxt_cnt >= count)
      begin
        nxt_run  = 1'b0;
        nxt_done = 1'b1;
      end
    end
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      cnt_ff  <= 4'h0;
      run_ff  <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      cnt_ff  <= nxt_cnt;
      run_ff  <= nxt_run;
      done_ff <= nxt_done;
    end
  end

endmodule

// File: sim/vasi_chk_assertions.sv
module vasi_chk (
  input wire       REF_CLK,              // clock
  input wire       RESET,                // reset
  input wire       SYSTEM_RESET_INPUT_N, // bus reset
  input wire       IACK_N,               // ack
  input wire       AS_N,                 // strobe
  input wire [2:0] IACK_LEVEL,           // level
  input wire       IACKIN_N,             // chain in
  input wire       FIRST_SLOT,           // slot one
  input wire       BERR_N,               // bus error
  input wire       SELFTEST_WR,          // write
  input wire       SLOT_ID_SELFTEST_BIT, // data
  input wire       IACKOUT_N,            // chain out
  input wire [7:0] SLOT_ID,              // id
  input wire       SLOT_ID_DONE_FLAG,    // done
  input wire       SELFTEST_BIT_Q        // held bit
);
  timeunit 1ns;
  timeprecision 1ns;
  reg  armed_ff;
  reg  busy_ff;
  wire start = armed_ff && !IACK_N && !AS_N && IACK_LEVEL == 3'h1;
  // Busy marks only the armed pass; later cycles are not ours to judge
  always @(posedge REF_CLK)
  begin
    armed_ff <= RESET || !SYSTEM_RESET_INPUT_N || (armed_ff && !start);
    busy_ff  <= !RESET && (start || busy_ff) && !IACK_N && BERR_N;
  end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  rst_vals_a: assert property ($fell(RESET) |-> IACKOUT_N && !SLOT_ID_DONE_FLAG && !SELFTEST_BIT_Q)
    else $error("reset values wrong");
  system_reset_input_clr_a: assert property (!SYSTEM_RESET_INPUT_N |=> !SLOT_ID_DONE_FLAG && $stable(SLOT_ID))
    else $error("bus reset effect wrong");
  first_out_a: assert property (start && FIRST_SLOT |-> IACKOUT_N[*4] ##[1:3] !IACKOUT_N)
    else $error("first slot pass time");
  pass_out_a: assert property (busy_ff && !FIRST_SLOT && $fell(IACKIN_N) |-> IACKOUT_N[*3] ##[1:4] !IACKOUT_N)
    else $error("chain pass time");
  out_rel_a: assert property (!BERR_N |-> ##[1:2] IACKOUT_N)
    else $error("chain out not released");
  done_set_a: assert property (busy_ff && !BERR_N |-> ##[1:3] SLOT_ID_DONE_FLAG)
    else $error("done flag late");
  id_hold_a: assert property (SLOT_ID_DONE_FLAG && !SELFTEST_WR && SYSTEM_RESET_INPUT_N |=> $stable(SLOT_ID))
    else $error("id changed");
  test_inc_a: assert property (SLOT_ID_DONE_FLAG && SELFTEST_WR && SLOT_ID_SELFTEST_BIT
    |=> SLOT_ID == $past(SLOT_ID) + 8'h01)
    else $error("self-test increment");
endmodule

bind vasi_auto_slot_id vasi_chk u_chk (.REF_CLK, .RESET, .SYSTEM_RESET_INPUT_N, .IACK_N, .AS_N, .IACK_LEVEL,
  .IACKIN_N, .FIRST_SLOT, .BERR_N, .SELFTEST_WR, .SLOT_ID_SELFTEST_BIT, .IACKOUT_N, .SLOT_ID,
  .SLOT_ID_DONE_FLAG, .SELFTEST_BIT_Q);

// File: sim/vasi_chain_model.sv
module vasi_chain_model (
  input  wire        clk,      // clock
  input  wire        go,       // start a cycle
  input  wire  [2:0] lvl,      // level to acknowledge
  input  int         dly,      // clocks until our chain input, 0 none
  input  int         tmo,      // clocks until the bus timer fires
  output logic       iack_n,   // ack
  output logic       as_n,     // strobe
  output logic [2:0] level,    // level code
  output logic       iackin_n, // chain in
  output logic       berr_n    // bus error
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {iack_n, as_n, iackin_n, berr_n, level} = 7'h78;
  // acknowledge issued directly, nobody claims it
  // no interrupter sits on the chain, so nothing halts the pass
  always @(posedge clk)
    if (go)
    begin
      #1 {iack_n, as_n, level} = {2'b00, lvl};
      for (int i = 1; i <= tmo; i++)
      begin
        @(posedge clk) #1;
        // upstream boards hand on after dly clocks
        if (i == dly) iackin_n = 1'b0;
      end
      // bus timer ends the idle cycle
      berr_n = 1'b0;
      repeat (2) @(posedge clk);
      // Released address lines show the inverse, not the old level
      #1 {iack_n, as_n, iackin_n, berr_n, level} = {4'hf, ~lvl};
    end
endmodule

// File: sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
  logic REF_CLK = 0, RESET = 1, SYSTEM_RESET_INPUT_N = 1, FIRST_SLOT = 0, SELFTEST_WR = 0;
  logic SLOT_ID_SELFTEST_BIT = 0, go = 0;
  logic [2:0]  lvl = 3'h1;
  logic [31:0] seed = 32'h0000_6c85;
  int          dly = 1, tmo = 11, e, n_mismatch = 0, samples_checked = 0;
  int          t_out = -1, prev_d = 1000;
  logic [7:0]  prev_id = 8'h00;
  wire         IACK_N, AS_N, IACKIN_N, BERR_N, IACKOUT_N, SLOT_ID_DONE_FLAG, SELFTEST_BIT_Q;
  wire [2:0]   IACK_LEVEL;
  wire [7:0]   SLOT_ID;
  always #25 REF_CLK = ~REF_CLK;
  vasi_chain_model far (.clk(REF_CLK), .go, .lvl, .dly, .tmo, .iack_n(IACK_N), .as_n(AS_N),
    .level(IACK_LEVEL), .iackin_n(IACKIN_N), .berr_n(BERR_N));
  vasi_auto_slot_id DUT (.REF_CLK, .RESET, .SYSTEM_RESET_INPUT_N, .IACK_N, .AS_N, .IACK_LEVEL, .IACKIN_N,
    .FIRST_SLOT, .BERR_N, .SELFTEST_WR, .SLOT_ID_SELFTEST_BIT, .IACKOUT_N, .SLOT_ID, .SLOT_ID_DONE_FLAG,
    .SELFTEST_BIT_Q);
  ////////////////////////////////////////////////////////////
  task automatic tick(int n);
    repeat (n) @(posedge REF_CLK);
    #1;
  endtask
  function automatic logic [31:0] xorshift(logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    r = r ^ (r << 5);
    return r;
  endfunction
  task automatic pass(logic [2:0] l, int d);
    lvl = l;
    dly = d;
    tmo = d + 10;
    t_out = -1;
    go = 1;
    tick(1);
    go = 0;
    // Note the first settled edge at which the chain output is low
    for (int k = 1; k <= d + 16; k++)
    begin
      tick(1);
      if (IACKOUT_N === 1'b0 && t_out < 0)
        t_out = k;
    end
  endtask
  task automatic selftest(logic b);
    SELFTEST_WR = 1;
    SLOT_ID_SELFTEST_BIT = b;
    tick(1);
    SELFTEST_WR = 0;
    tick(2);
  endtask
  task automatic conclude();
    $display("compared %0d, mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    tick(12);
    RESET = 0;
    `CHK("selftest bit", 1'b0, SELFTEST_BIT_Q)
    pass(3'h2, 6);
    `CHK("done on level two", 1'b0, SLOT_ID_DONE_FLAG)
    `CHK("out on level two", -1, t_out)
    $display("level two pass ended");
    for (int i = 0; i < 6; i++)
    begin
      seed = xorshift(seed);
      SYSTEM_RESET_INPUT_N = 0;
      tick(1);
      SYSTEM_RESET_INPUT_N = 1;
      pass(3'h1, 1 + seed % 40);
      // Capture lands one clock after the chain input; one count of slack
      e = (dly + 2) / 4;
      `CHK("done", 1'b1, SLOT_ID_DONE_FLAG)
      `CHK("out time", dly + 5, t_out)
      // control register is read before the identifier
      `CHK("selftest bit cleared", 1'b0, SELFTEST_BIT_Q)
      `CHK("id near", 1'b1, (SLOT_ID - 8'(e) + 8'h01) <= 8'h02)
      if (dly >= prev_d + 4)
        `CHK("id order", 1'b1, SLOT_ID > prev_id)
      prev_d = dly;
      prev_id = SLOT_ID;
      pass(3'h1, dly + 12);
      `CHK("out when done", -1, t_out)
      `CHK("id kept", 1'b1, (SLOT_ID - 8'(e) + 8'h01) <= 8'h02)
      selftest(1'b0);
      selftest(1'b1);
      `CHK("selftest bit held", 1'b1, SELFTEST_BIT_Q)
      `CHK("id bumped", prev_id + 8'h01, SLOT_ID)
      $display("pass with chain delay %0d ended", prev_d);
    end
    FIRST_SLOT = 1;
    SYSTEM_RESET_INPUT_N = 0;
    tick(1);
    SYSTEM_RESET_INPUT_N = 1;
    pass(3'h1, 0);
    `CHK("first slot done", 1'b1, SLOT_ID_DONE_FLAG)
    `CHK("first slot out time", 6, t_out)
    `CHK("selftest cleared again", 1'b0, SELFTEST_BIT_Q)
    `CHK("first slot id", 1'b1, SLOT_ID <= 8'h01)
    $display("first slot pass ended");
    conclude();
  end
  initial
  begin
    #(50 * 6000);
    n_mismatch++;
    conclude();
  end
endmodule
